// [rtl/press_setup_cfg.svh]
`ifndef PRESS_SETUP_CFG_SVH
`define PRESS_SETUP_CFG_SVH

// scan clock rate in kHz
`define CLK_KHZ 20000

// restart pulse limits, in their own units
`define RST_MIN_SHORT_MS 100
`define RST_MIN_LONG_MS 350
`define RST_MAX_S 30

// restart pulse limits in scan cycles
`define RST_MIN_SHORT_CYC (`RST_MIN_SHORT_MS * `CLK_KHZ)
`define RST_MIN_LONG_CYC (`RST_MIN_LONG_MS * `CLK_KHZ)
`define RST_MAX_CYC (`RST_MAX_S * 1000 * `CLK_KHZ)
`define RST_CNT_W 30

// register byte addresses
`define CTRL_ADDR 8'h00
`define STAT_ADDR 8'h04

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_EN2_BIT 3
`define CTRL_SINGLE_BIT 4
`define CTRL_LONG_BIT 5
`define CTRL_MODE_RST 3'h2

// status register fields
`define STAT_ENABLE_BIT 0
`define STAT_REQ_BIT 1
`define STAT_ARMED_BIT 2
`define STAT_EN1N_BIT 3
`define STAT_PINS_LSB 8

`endif

// [rtl/press_setup_pkg.sv]
package press_setup_pkg;

    // interlock mode, coded as the printed mode number
    typedef enum logic [2:0] {
        MODE_WITHOUT = 3'h1,
        MODE_ALWAYS = 3'h2,
        MODE_ONOFF = 3'h3,
        MODE_TOP = 3'h4
    } mode_t;

    // operator and safety pins, raw from outside
    typedef struct packed {
        logic restart;
        logic top;
        logic en2;
        logic en1;
        logic on_start;
    } press_in_t;

    // software configuration
    typedef struct packed {
        logic long_pulse;
        logic single_stroke;
        logic en2_used;
        mode_t mode;
    } ctrl_t;

endpackage

// [rtl/pin_sync_edge.sv]
`timescale 1ns/1ns
`default_nettype none

module pin_sync_edge
#(
    parameter int W = 5
)
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // raw pins
    input wire logic [W-1:0] pin_raw,
    // synchronised level and edges
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    // two-stage synchroniser, then one-scan history
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else if (ce)
        begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // edges against previous scan
    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg; // R18
    assign fall = ~sync_reg & prev_reg; // R18

endmodule

`default_nettype wire

// [rtl/restart_pulse_check.sv]
`timescale 1ns/1ns
`default_nettype none

`include "press_setup_cfg.svh"

module restart_pulse_check
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // synchronised restart edges
    input wire logic pulse_rise,
    input wire logic pulse_fall,
    // accepted width window in scan cycles
    input wire logic [`RST_CNT_W-1:0] min_cyc,
    input wire logic [`RST_CNT_W-1:0] max_cyc,
    // one-scan pulse on a valid low-high-low
    output logic valid
);

    logic counting_reg;
    logic [`RST_CNT_W-1:0] cnt_reg;
    logic [`RST_CNT_W-1:0] cnt_next;

    // saturating high-time counter
    always_comb
    begin
        cnt_next = cnt_reg;
        if (cnt_reg != {`RST_CNT_W{1'b1}})
            cnt_next = cnt_reg + `RST_CNT_W'(1);
    end

    // a pulse counts only once its rising edge was seen
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            counting_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else if (ce)
        begin
            if (pulse_rise)
            begin
                counting_reg <= 1'b1;
                cnt_reg <= `RST_CNT_W'(1);
            end
            else if (pulse_fall)
                counting_reg <= 1'b0;
            else if (counting_reg)
                cnt_reg <= cnt_next; // R18
        end
    end

    // width check on the falling edge
    assign valid = ce && pulse_fall && counting_reg
        && (cnt_reg >= min_cyc) // R11
        && (cnt_reg <= max_cyc); // R15

endmodule

`default_nettype wire

// [rtl/press_setup_enable_control.sv]
// What this block does
// [R1] Enable drops at once whenever the main permit is low.
// [R2] Start-only permit is checked only while enable is low.
// [R3] Start/stop rising edge requests start; falling edge stops the press.
// [R4] Inverted-permit output always mirrors the main permit inverted.
// [R5] With single stroke on, a top rising edge ends the stroke.
// [R6] Restart-required shows the interlock only while permits are high.
// [R7] Mode 1 never arms; a new start edge resumes after any stop.
// [R8] Mode 2 arms at start and on every stop.
// [R9] Mode 3 arms at start and on start/stop or permit stops.
// [R10] Mode 4 arms at start and on top or permit stops.
// [R11] Restart high phase shorter than 100 or 350 ms is rejected.
// [R12] A valid restart pulse clears the interlock and restart-required.
// [R13] Start-only permit is used only when its option is on.
// [R14] With single stroke off the top input never stops the press.
// [R15] Restart high phases over 30 s are ignored too.
// [R16] Enable stays low while restart-required is high.
// [R17] Enable rises only on a start edge with all permits met.
// [R18] Edges come from comparing each input with its previous scan.
//
// Local design decisions: the APB interface to the registers and the register addresses.

`timescale 1ns/1ns
`default_nettype none

`include "press_setup_cfg.svh"

module press_setup_enable_control
#(
    parameter logic [`RST_CNT_W-1:0] MIN_SHORT_CYC =
        `RST_CNT_W'(`RST_MIN_SHORT_CYC),
    parameter logic [`RST_CNT_W-1:0] MIN_LONG_CYC =
        `RST_CNT_W'(`RST_MIN_LONG_CYC),
    parameter logic [`RST_CNT_W-1:0] MAX_CYC =
        `RST_CNT_W'(`RST_MAX_CYC)
)
(
    // clock, reset, clock enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // operator and safety pins
    input wire press_setup_pkg::press_in_t PINS,
    // press drive outputs
    output logic ENABLE,
    output logic RESTART_REQUIRED,
    output logic EN1_INVERTED
);

    import press_setup_pkg::*;

    press_in_t pin_lvl;
    press_in_t pin_rise;
    press_in_t pin_fall;
    ctrl_t ctrl_reg;
    mode_t mode_eff;
    logic armed_reg;
    logic enable_reg;
    logic enable_next;
    logic restart_valid;
    logic en2_ok;
    logic permits_ok;
    logic req;
    logic stop_onoff;
    logic stop_top;
    logic stop_en1;
    logic arm_event;
    logic start_req;
    logic [`RST_CNT_W-1:0] min_cyc;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic wr_access;
    logic rd_setup;

    // pin synchronisers and edge detection
    pin_sync_edge #(
        .W($bits(press_in_t))
    ) u_sync (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .pin_raw(PINS),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // restart width selection
    assign min_cyc = ctrl_reg.long_pulse ? MIN_LONG_CYC : MIN_SHORT_CYC; // R11

    // restart pulse width check
    restart_pulse_check u_restart (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .pulse_rise(pin_rise.restart),
        .pulse_fall(pin_fall.restart),
        .min_cyc(min_cyc),
        .max_cyc(MAX_CYC),
        .valid(restart_valid)
    );

    // unknown mode codes fall back to the strictest mode
    always_comb
    begin
        case (ctrl_reg.mode)
            MODE_WITHOUT: mode_eff = MODE_WITHOUT;
            MODE_ALWAYS: mode_eff = MODE_ALWAYS;
            MODE_ONOFF: mode_eff = MODE_ONOFF;
            MODE_TOP: mode_eff = MODE_TOP;
            default: mode_eff = MODE_ALWAYS;
        endcase
    end

    // start-only permit, ignored when not configured
    assign en2_ok = !ctrl_reg.en2_used || pin_lvl.en2; // R13
    assign permits_ok = pin_lvl.en1 && en2_ok;

    // stop causes seen this scan
    assign stop_onoff = pin_fall.on_start && enable_reg; // R3
    assign stop_top = ctrl_reg.single_stroke && pin_rise.top
        && enable_reg; // R5 R14
    assign stop_en1 = pin_fall.en1;

    // which stops arm the interlock in the current mode
    always_comb
    begin
        case (mode_eff)
            MODE_WITHOUT: arm_event = 1'b0; // R7
            MODE_ALWAYS: arm_event = stop_onoff || stop_top
                || stop_en1; // R8
            MODE_ONOFF: arm_event = stop_onoff || stop_en1; // R9
            MODE_TOP: arm_event = stop_top || stop_en1; // R10
            default: arm_event = stop_onoff || stop_top || stop_en1;
        endcase
    end

    // interlock flag; arming wins over a clearing restart
    always_ff @(posedge CLK)
    begin
        if (RST)
            armed_reg <= 1'b1; // R8 R9 R10
        else if (CE)
        begin
            if (mode_eff == MODE_WITHOUT)
                armed_reg <= 1'b0; // R7
            else if (arm_event)
                armed_reg <= 1'b1;
            else if (restart_valid)
                armed_reg <= 1'b0; // R12
        end
    end

    // interlock shown only when a restart could be accepted
    assign req = armed_reg && permits_ok
        && (mode_eff != MODE_WITHOUT); // R6 R7

    // start request with every precondition met
    assign start_req = pin_rise.on_start && !armed_reg
        && permits_ok; // R17 R2

    // next enable: stops first, then start
    always_comb
    begin
        enable_next = enable_reg;
        if (!pin_lvl.en1)
            enable_next = 1'b0; // R1
        else if (pin_fall.on_start)
            enable_next = 1'b0; // R3
        else if (ctrl_reg.single_stroke && pin_rise.top)
            enable_next = 1'b0; // R5
        else if (armed_reg)
            enable_next = 1'b0; // R16
        else if (!enable_reg && start_req)
            enable_next = 1'b1; // R3 R17
    end

    // enable flip-flop; start-only permit no longer looked at once high
    always_ff @(posedge CLK)
    begin
        if (RST)
            enable_reg <= 1'b0;
        else if (CE)
            enable_reg <= enable_next; // R2
    end

    // drive outputs
    assign ENABLE = enable_reg && pin_lvl.en1 && !req; // R1 R16
    assign RESTART_REQUIRED = req; // R6
    assign EN1_INVERTED = !pin_lvl.en1; // R4

    // register select, shared by the write and read paths
    function automatic logic addr_hit(
        input logic [7:0] a,
        input logic [7:0] r
    );
        return a == r;
    endfunction

    // apb phase decode
    assign wr_access = CE && PSEL && PENABLE && PWRITE;
    assign rd_setup = CE && PSEL && !PENABLE;

    // control register write
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl_reg.mode <= mode_t'(`CTRL_MODE_RST);
            ctrl_reg.en2_used <= 1'b0;
            ctrl_reg.single_stroke <= 1'b0;
            ctrl_reg.long_pulse <= 1'b0;
        end
        else if (wr_access && addr_hit(PADDR, `CTRL_ADDR))
        begin
            ctrl_reg.mode <= mode_t'(PWDATA[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
            ctrl_reg.en2_used <= PWDATA[`CTRL_EN2_BIT];
            ctrl_reg.single_stroke <= PWDATA[`CTRL_SINGLE_BIT];
            ctrl_reg.long_pulse <= PWDATA[`CTRL_LONG_BIT];
        end
    end

    // readback words
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = ctrl_reg.mode;
        ctrl_word[`CTRL_EN2_BIT] = ctrl_reg.en2_used;
        ctrl_word[`CTRL_SINGLE_BIT] = ctrl_reg.single_stroke;
        ctrl_word[`CTRL_LONG_BIT] = ctrl_reg.long_pulse;
        stat_word = '0;
        stat_word[`STAT_ENABLE_BIT] = ENABLE;
        stat_word[`STAT_REQ_BIT] = req;
        stat_word[`STAT_ARMED_BIT] = armed_reg;
        stat_word[`STAT_EN1N_BIT] = !pin_lvl.en1;
        stat_word[`STAT_PINS_LSB +: $bits(press_in_t)] = pin_lvl;
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end
        else if (rd_setup)
        begin
            if (addr_hit(PADDR, `CTRL_ADDR))
            begin
                prdata_reg <= PWRITE ? 32'h0000_0000 : ctrl_word;
                pslverr_reg <= 1'b0;
            end
            else if (addr_hit(PADDR, `STAT_ADDR))
            begin
                prdata_reg <= PWRITE ? 32'h0000_0000 : stat_word;
                pslverr_reg <= PWRITE;
            end
            else
            begin
                prdata_reg <= 32'h0000_0000;
                pslverr_reg <= 1'b1;
            end
        end
    end

    // zero-wait answer, stalled while the clock enable is low
    assign PREADY = CE;
    assign PRDATA = prdata_reg;
    assign PSLVERR = pslverr_reg && PSEL && PENABLE;

endmodule

`default_nettype wire

// [tb/press_pins_model.sv]
`timescale 1ns/1ns
`default_nettype none

module press_pins_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels {top,en2,en1,on_start} and pulse request
    input wire logic [3:0] lvl,
    input wire logic go,
    input wire logic [7:0] len,
    // pins toward the block
    output var press_setup_pkg::press_in_t pins
);
    import press_setup_pkg::*;
    logic [7:0] cnt_reg;

    // restart held high for len scans
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_reg <= 8'h00;
        else if (go)
            cnt_reg <= len;
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end

    // restart first, then the static levels
    assign pins = {cnt_reg != 8'h00, lvl};
endmodule

`default_nettype wire

// [tb/press_setup_monitor.sv]
`timescale 1ns/1ns
`default_nettype none

module press_setup_monitor
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // pins and outputs
    input wire press_setup_pkg::press_in_t PINS,
    input wire logic ENABLE,
    input wire logic RESTART_REQUIRED,
    input wire logic EN1_INVERTED
);
    import press_setup_pkg::*;
    ctrl_t ctrl;
    logic [2:0] up;

    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);

    // shadow of the control word
    always_ff @(posedge CLK)
    begin
        if (RST)
            ctrl <= ctrl_t'(6'h02);
        else if (PSEL && PENABLE && PWRITE && PREADY && PADDR == 8'h00)
            ctrl <= ctrl_t'(PWDATA[5:0]);
    end

    // scans since reset, saturating
    always_ff @(posedge CLK)
    begin
        if (RST)
            up <= 3'h0;
        else if (up != 3'h7)
            up <= up + 3'h1;
    end

    sequence permit_low;
        !PINS.en1 [*3];
    endsequence
    sequence top_rise;
        ctrl.single_stroke && $rose(PINS.top);
    endsequence

    en1_drop_a: assert property (permit_low |-> !ENABLE)
        else $error("enable high with permit low");
    inv_permit_a: assert property (up == 3'h7 ##0 $stable(PINS.en1) [*3]
        |-> EN1_INVERTED == !PINS.en1) else $error("inverted permit wrong");
    req_gate_a: assert property (RESTART_REQUIRED |-> $past(PINS.en1, 2))
        else $error("restart required shown without permit");
    req_blocks_a: assert property (ENABLE |-> !RESTART_REQUIRED)
        else $error("enable high while restart required");
    start_cause_a: assert property ($rose(ENABLE)
        |-> $past(PINS.on_start, 2) && $past(PINS.en1, 2))
        else $error("enable rose without start");
    stop_edge_a: assert property (!PINS.on_start [*5] |-> !ENABLE)
        else $error("enable high with start low");
    top_stop_a: assert property (top_rise |-> ##4 !ENABLE)
        else $error("top edge did not stop");
    mode1_clear_a: assert property (ctrl.mode == MODE_WITHOUT
        && $past(ctrl.mode) == MODE_WITHOUT |-> !RESTART_REQUIRED)
        else $error("interlock in mode 1");
    req_clear_a: assert property ($fell(RESTART_REQUIRED) |->
        !$past(PINS.restart, 2) || !$past(PINS.en1, 2)
        || !$past(PINS.en2, 2) || ctrl.mode == MODE_WITHOUT)
        else $error("restart required fell without cause");
    bad_addr_a: assert property (PSEL && PENABLE && PADDR > 8'h04
        |-> PSLVERR && PREADY) else $error("unmapped access not refused");
endmodule

`default_nettype wire

// [tb/press_setup_enable_control_test.sv]
`timescale 1ns/1ns
`default_nettype none

module press_setup_enable_control_test;
    import press_setup_pkg::*;
    logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e, go;
    logic ENABLE, RESTART_REQUIRED, EN1_INVERTED;
    logic [7:0] PADDR, len;
    logic [3:0] lvl;
    logic [31:0] PWDATA, PRDATA, q;
    press_in_t PINS;
    int n_errors, n_tests, m, k;

    press_setup_enable_control
    #(
        .MIN_SHORT_CYC(30'd10),
        .MIN_LONG_CYC(30'd20),
        .MAX_CYC(30'd100)
    )
    press_setup_enable_control_i
    (
        .CLK(CLK), .RST(RST), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PINS(PINS), .ENABLE(ENABLE),
        .RESTART_REQUIRED(RESTART_REQUIRED), .EN1_INVERTED(EN1_INVERTED)
    );

    press_pins_model press_pins_model_i
    (
        .clk(CLK), .rst(RST), .lvl(lvl), .go(go), .len(len), .pins(PINS)
    );

    // 20 mhz scan clock
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] x);
        n_tests++;
        if (got !== x)
        begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, x, got);
        end
    endtask

    task final_report;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task run(input int n);
        repeat (n) @(posedge CLK);
    endtask

    // one apb transfer, result in q and e
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge CLK);
            if (PREADY === 1'b1)
                break;
        end
        if (n == 20)
        begin
            n_errors++;
            final_report;
        end
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task set(input logic [3:0] v);
        lvl <= v;
        run(6);
    endtask

    task pulse(input logic [7:0] n);
        len <= n;
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        run(int'(n) + 12);
    endtask

    task t_boot;
        chk("inv low", EN1_INVERTED, 1'b1);
        chk("req hidden", RESTART_REQUIRED, 1'b0);
        set(4'b0010);
        chk("inv high", EN1_INVERTED, 1'b0);
        chk("armed", RESTART_REQUIRED, 1'b1);
        set(4'b0011);
        chk("blocked", ENABLE, 1'b0);
        set(4'b0010);
        $display("done boot");
    endtask

    task t_pulse;
        pulse(8'd9);
        chk("short", RESTART_REQUIRED, 1'b1);
        pulse(8'd101);
        chk("overlong", RESTART_REQUIRED, 1'b1);
        pulse(8'd10);
        chk("valid", RESTART_REQUIRED, 1'b0);
        apb(1'b1, 8'h00, 32'h22);
        set(4'b0000);
        set(4'b0010);
        pulse(8'd19);
        chk("short long", RESTART_REQUIRED, 1'b1);
        pulse(8'd20);
        chk("valid long", RESTART_REQUIRED, 1'b0);
        $display("done pulse");
    endtask

    // start, stop by kind k, check interlock for mode m
    task t_stop(input logic [2:0] m, input logic [1:0] k);
        logic arm;
        arm = m == 3'h2 || (k == 2'h2 && m != 3'h1)
            || (m == 3'h3 && k == 2'h0) || (m == 3'h4 && k == 2'h1);
        apb(1'b1, 8'h00, {26'h0, 3'b010, m});
        set(4'b0010);
        pulse(8'd10);
        set(4'b0011);
        chk("started", ENABLE, 1'b1);
        set(k == 2'h0 ? 4'b0010 : k == 2'h1 ? 4'b1011 : 4'b0001);
        chk("stopped", ENABLE, 1'b0);
        set(4'b0010);
        chk("interlock", RESTART_REQUIRED, arm);
        pulse(8'd10);
        chk("cleared", RESTART_REQUIRED, 1'b0);
    endtask

    task t_opts;
        apb(1'b1, 8'h00, 32'h1);
        set(4'b0011);
        set(4'b1011);
        chk("top ignored", ENABLE, 1'b1);
        set(4'b0010);
        apb(1'b1, 8'h00, 32'h9);
        set(4'b0011);
        chk("en2 refused", ENABLE, 1'b0);
        set(4'b0110);
        set(4'b0111);
        chk("en2 met", ENABLE, 1'b1);
        set(4'b0011);
        chk("en2 unwatched", ENABLE, 1'b1);
        set(4'b0010);
        $display("done options");
    endtask

    task t_regs;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", q, 32'h9);
        apb(1'b0, 8'h04, 32'h0);
        chk("status", q, 32'h200);
        apb(1'b1, 8'h00, 32'h35);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl rw", q, 32'h35);
        apb(1'b1, 8'h04, 32'h0);
        chk("status ro", e, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", {q[30:0], e}, 32'h1);
        $display("done regs");
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        {RST, PSEL, PENABLE, PWRITE, go} = 5'h10;
        {PADDR, len, lvl, PWDATA} = 52'h0;
        n_errors = 0;
        n_tests = 0;
        run(16);
        RST <= 1'b0;
        t_boot;
        t_pulse;
        for (m = 1; m <= 4; m++)
            for (k = 0; k < 3; k++)
                t_stop(m[2:0], k[1:0]);
        $display("done stops");
        t_opts;
        t_regs;
        final_report;
    end
endmodule

bind press_setup_enable_control press_setup_monitor press_setup_monitor_i
(
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PINS(PINS), .ENABLE(ENABLE), .RESTART_REQUIRED(RESTART_REQUIRED),
    .EN1_INVERTED(EN1_INVERTED)
);

`default_nettype wire
